//--- design/fcii_consts.vh
`ifndef FCII_CONSTS_VH
`define FCII_CONSTS_VH

// instruction classes presented by the host with each issue
`define FCII_CLS_DP         3'h0
`define FCII_CLS_LOAD       3'h1
`define FCII_CLS_STORE      3'h2
`define FCII_CLS_STORE_MULT 3'h3
`define FCII_CLS_TO_CORE    3'h4
`define FCII_CLS_SYS_RD     3'h5
`define FCII_CLS_SYS_WR     3'h6
`define FCII_CLS_FLAG       3'h7

// system register selects for read, write and flag transfer
`define FCII_SEL_ID         3'h0
`define FCII_SEL_STATUS     3'h1
`define FCII_SEL_EXC        3'h2
`define FCII_SEL_SAVED      3'h3
`define FCII_SEL_SAVED2     3'h4

// timing, in cycles of the 10 ns clock
`define FCII_CNT_W          10
`define FCII_FMAC_LAT       10'h008
`define FCII_DS_SP_STEP     10'h00e
`define FCII_DS_DP_STEP     10'h01c
`define FCII_DS_TAIL        10'h002
`define FCII_MAX_UNAVAIL    10'h072
`define FCII_LS_LAT         10'h002
`define FCII_CNT_ONE        10'h001
`define FCII_CNT_ZERO       10'h000

`endif

//--- design/fcii_issue_interlock.v
`timescale 1ns/1ps
`include "fcii_consts.vh"

// How it works
// - serializing access holds issue until pipeline settles
// - sysreg read waits for all prior completion
// - status register write waits for arithmetic drain
// - exception or saved register write waits fully
// - identification access serializes, contents never change
// - host change of flow kills issuing instruction
// - host condition failure cancels the same instruction
// - aborted load/store leaves state for restart
// - multiple transfer restarts at first, source locks released on abort
// - dependents of load/store wait for completion
// - issued short vector runs uninterrupted to end
// - worst unavailability capped at 114 cycles
// - forward load/dp results, one cycle earlier
// - no forwarding from integer-producing instructions
// - stores and to-core transfers never get forwarding
// - no forwarding across precisions
// - scoreboards hold issue until registers free
// - detect read/write ordering hazards in all forms
// - fast mode skips source locks for arithmetic
module fcii_issue_interlock #(
    parameter NREG = 32
) (
    input  wire            clock_i,
    input  wire            rst_n_i,
    input  wire            instr_valid_i,  // host offers an instruction
    input  wire [2:0]      instr_class_i,  // class, see consts
    input  wire [2:0]      sysreg_sel_i,   // system register select
    input  wire [NREG-1:0] src_mask_i,     // source registers, all iterations
    input  wire [NREG-1:0] dst_mask_i,     // destination registers, all iterations
    input  wire            dbl_i,          // double precision
    input  wire            int_result_i,   // result is integer data
    input  wire            divsqrt_i,      // divide or square root
    input  wire [2:0]      vec_len_i,      // iterations minus one
    input  wire [4:0]      xfer_cnt_i,     // transfers minus one
    input  wire            fast_mode_i,    // fast mode selected
    input  wire            cond_fail_i,    // host condition check failed
    input  wire            flush_i,        // host change of flow
    input  wire            abort_i,        // data abort on the load/store
    input  wire            mem_wait_i,     // memory not ready this cycle
    output reg             stall_o,        // host must hold its pipeline
    output reg             issue_go_o,     // instruction left issue
    output reg             issue_cancel_o, // instruction cancelled at issue
    output reg             fwd_used_o,     // issue used a forwarded operand
    output reg             dp_busy_o,      // arithmetic pipe busy
    output reg             ls_busy_o,      // load/store pipe busy
    output reg             unavail_o,      // short vector running, not interruptible
    output reg             ls_restart_o,   // load/store aborted, ready to reissue
    output reg  [4:0]      ls_xfer_idx_o   // next transfer index of load/store
);

    // issue stage slot
    reg             slot_v_q;             // slot holds an instruction
    reg [2:0]       slot_cls_q;           // its class
    reg [2:0]       slot_sel_q;           // its system register select
    reg [NREG-1:0]  slot_src_q;           // its source mask
    reg [NREG-1:0]  slot_dst_q;           // its destination mask
    reg             slot_dbl_q;           // its precision
    reg             slot_int_q;           // integer result
    reg             slot_ds_q;            // divide or square root
    reg [2:0]       slot_len_q;           // iterations minus one
    reg [4:0]       slot_xfer_q;          // transfers minus one
    reg             slot_fast_q;          // fast mode at capture

    // arithmetic pipe tracking, one op in flight plus overlap in its last cycle
    reg [`FCII_CNT_W-1:0] dp_cnt_q;       // cycles until writeback
    reg [NREG-1:0]  dp_dst_q;             // destinations of the op in flight
    reg [NREG-1:0]  dp_src_q;             // sources it still holds
    reg             dp_dbl_q;             // precision of its result
    reg             dp_int_q;             // integer result
    reg             dp_vec_q;             // short vector in flight

    // load/store pipe tracking
    reg [`FCII_CNT_W-1:0] ls_cnt_q;       // cycles until completion
    reg [NREG-1:0]  ls_dst_q;             // load destinations
    reg [NREG-1:0]  ls_src_q;             // store sources
    reg             ls_load_q;            // operation is a load
    reg             ls_dbl_q;             // precision of load data

    wire [NREG-1:0] dst_lock;             // destination scoreboard
    wire [NREG-1:0] src_lock;             // source scoreboard

    // decoded slot attributes
    reg             is_dp;
    reg             is_ls;
    reg             is_load;
    reg             is_sys;
    reg             dp_last;
    reg             ls_last;
    reg             fwd_dp_ok;
    reg             fwd_ls_ok;
    reg [NREG-1:0]  fwd_free;
    reg             blk_haz;
    reg             blk_res;
    reg             blk_ser;
    reg             kill;
    reg             go;
    reg             accept;
    reg             slot_v_d;
    reg [`FCII_CNT_W-1:0] iters;
    reg [`FCII_CNT_W-1:0] dur;
    reg [NREG-1:0]  dst_set;
    reg [NREG-1:0]  src_set;
    reg [NREG-1:0]  dst_clr;
    reg [NREG-1:0]  src_clr;
    reg             ls_abort;

    // hazard, serialization and issue decision
    always @* begin
        is_dp   = (slot_cls_q == `FCII_CLS_DP);
        is_load = (slot_cls_q == `FCII_CLS_LOAD);
        is_ls   = is_load | (slot_cls_q == `FCII_CLS_STORE) |
                  (slot_cls_q == `FCII_CLS_STORE_MULT) |
                  (slot_cls_q == `FCII_CLS_TO_CORE);
        is_sys  = (slot_cls_q == `FCII_CLS_SYS_RD) |
                  (slot_cls_q == `FCII_CLS_SYS_WR) |
                  (slot_cls_q == `FCII_CLS_FLAG);
        dp_last = (dp_cnt_q == `FCII_CNT_ONE);
        ls_last = (ls_cnt_q == `FCII_CNT_ONE) & ~mem_wait_i;
        ls_abort = abort_i & (ls_cnt_q != `FCII_CNT_ZERO);
        // forwarding only into arithmetic, same precision, non-integer source
        fwd_dp_ok = is_dp & dp_last & ~dp_int_q & (dp_dbl_q == slot_dbl_q);
        fwd_ls_ok = is_dp & ls_last & ls_load_q & (ls_dbl_q == slot_dbl_q) &
                    ~ls_abort;
        fwd_free = (fwd_dp_ok ? dp_dst_q : {NREG{1'b0}}) |
                   (fwd_ls_ok ? ls_dst_q : {NREG{1'b0}});
        // read-after-write, write-after-write, write-after-read
        blk_haz = |(slot_src_q & dst_lock & ~fwd_free) |
                  |(slot_dst_q & dst_lock) |
                  |(slot_dst_q & src_lock);
        // one op per pipe; arithmetic may overlap its predecessor's last cycle
        blk_res = (is_dp & (dp_cnt_q != `FCII_CNT_ZERO) & ~dp_last) |
                  (is_ls & (ls_cnt_q != `FCII_CNT_ZERO));
        // serializing accesses wait on pipe activity, not registers
        blk_ser = 1'b0;
        if (is_sys) begin
            if (slot_cls_q == `FCII_CLS_SYS_WR && slot_sel_q == `FCII_SEL_STATUS) begin
                // control bits only reach arithmetic ops, loads are untouched
                blk_ser = (dp_cnt_q != `FCII_CNT_ZERO);
            end else if (slot_cls_q == `FCII_CLS_SYS_WR) begin
                // exception, saved and identification writes need a clear pipe
                blk_ser = (dp_cnt_q != `FCII_CNT_ZERO) |
                          (ls_cnt_q != `FCII_CNT_ZERO);
            end else begin
                // reads and flag transfer wait for every prior op and flags
                blk_ser = (dp_cnt_q != `FCII_CNT_ZERO) |
                          (ls_cnt_q != `FCII_CNT_ZERO);
            end
        end
        kill     = slot_v_q & (cond_fail_i | flush_i);
        go       = slot_v_q & ~kill & ~blk_haz & ~blk_res & ~blk_ser;
        accept   = instr_valid_i & ~stall_o;
        slot_v_d = (slot_v_q & ~go & ~kill) | accept;
    end

    // duration and lock masks of the issuing op
    always @* begin
        iters = {{(`FCII_CNT_W-3){1'b0}}, slot_len_q} + `FCII_CNT_ONE;
        if (slot_ds_q) begin
            dur = iters * (slot_dbl_q ? `FCII_DS_DP_STEP : `FCII_DS_SP_STEP) +
                  `FCII_DS_TAIL;
        end else begin
            dur = iters - `FCII_CNT_ONE + `FCII_FMAC_LAT;
        end
        // worst case is the eight-iteration double divide/root, clamped to the cap
        if (dur > `FCII_MAX_UNAVAIL) begin
            dur = `FCII_MAX_UNAVAIL;
        end
        dst_set = {NREG{1'b0}};
        src_set = {NREG{1'b0}};
        if (go && is_dp) begin
            dst_set = slot_dst_q;
            // fast mode never bounces, so sources need not be preserved
            src_set = slot_fast_q ? {NREG{1'b0}} : slot_src_q;
        end else if (go && is_ls) begin
            dst_set = is_load ? slot_dst_q : {NREG{1'b0}};
            src_set = is_load ? {NREG{1'b0}} : slot_src_q;
        end
        dst_clr = (dp_last ? dp_dst_q : {NREG{1'b0}}) |
                  ((ls_last | ls_abort) ? ls_dst_q : {NREG{1'b0}});
        src_clr = (dp_last ? dp_src_q : {NREG{1'b0}}) |
                  ((ls_last | ls_abort) ? ls_src_q : {NREG{1'b0}});
    end

    // destination scoreboard
    fcii_lock_bank #(
        .NREG    (NREG)
    ) u_dst_lock (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .set_i   (dst_set),
        .clr_i   (dst_clr),
        .lock_o  (dst_lock)
    );

    // source scoreboard
    fcii_lock_bank #(
        .NREG    (NREG)
    ) u_src_lock (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .set_i   (src_set),
        .clr_i   (src_clr),
        .lock_o  (src_lock)
    );

    // issue slot capture; fields only load on accept
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_v_q    <= 1'b0;
            slot_cls_q  <= `FCII_CLS_DP;
            slot_sel_q  <= `FCII_SEL_ID;
            slot_src_q  <= {NREG{1'b0}};
            slot_dst_q  <= {NREG{1'b0}};
            slot_dbl_q  <= 1'b0;
            slot_int_q  <= 1'b0;
            slot_ds_q   <= 1'b0;
            slot_len_q  <= 3'h0;
            slot_xfer_q <= 5'h00;
            slot_fast_q <= 1'b0;
        end else begin
            slot_v_q <= slot_v_d;
            if (accept) begin
                slot_cls_q  <= instr_class_i;
                slot_sel_q  <= sysreg_sel_i;
                slot_src_q  <= src_mask_i;
                slot_dst_q  <= dst_mask_i;
                slot_dbl_q  <= dbl_i;
                slot_int_q  <= int_result_i;
                slot_ds_q   <= divsqrt_i;
                slot_len_q  <= vec_len_i;
                slot_xfer_q <= xfer_cnt_i;
                slot_fast_q <= fast_mode_i;
            end
        end
    end

    // arithmetic pipe: once issued, nothing from the host stops it
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_cnt_q <= `FCII_CNT_ZERO;
            dp_dst_q <= {NREG{1'b0}};
            dp_src_q <= {NREG{1'b0}};
            dp_dbl_q <= 1'b0;
            dp_int_q <= 1'b0;
            dp_vec_q <= 1'b0;
        end else if (go && is_dp) begin
            dp_cnt_q <= dur;
            dp_dst_q <= slot_dst_q;
            dp_src_q <= src_set;
            dp_dbl_q <= slot_dbl_q;
            dp_int_q <= slot_int_q;
            dp_vec_q <= (slot_len_q != 3'h0);
        end else if (dp_cnt_q != `FCII_CNT_ZERO) begin
            // flush and abort deliberately ignored here
            dp_cnt_q <= dp_cnt_q - `FCII_CNT_ONE;
            if (dp_last) begin
                dp_dst_q <= {NREG{1'b0}};
                dp_src_q <= {NREG{1'b0}};
                dp_vec_q <= 1'b0;
            end
        end
    end

    // load/store pipe: stalls on memory, drops counter, locks and index on abort
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ls_cnt_q      <= `FCII_CNT_ZERO;
            ls_dst_q      <= {NREG{1'b0}};
            ls_src_q      <= {NREG{1'b0}};
            ls_load_q     <= 1'b0;
            ls_dbl_q      <= 1'b0;
            ls_xfer_idx_o <= 5'h00;
        end else if (ls_abort) begin
            // no register committed as done, so reissue restarts at first
            ls_cnt_q      <= `FCII_CNT_ZERO;
            ls_dst_q      <= {NREG{1'b0}};
            ls_src_q      <= {NREG{1'b0}};
            ls_xfer_idx_o <= 5'h00;
        end else if (go && is_ls) begin
            ls_cnt_q      <= {{(`FCII_CNT_W-5){1'b0}}, slot_xfer_q} + `FCII_LS_LAT;
            ls_dst_q      <= dst_set;
            ls_src_q      <= src_set;
            ls_load_q     <= is_load;
            ls_dbl_q      <= slot_dbl_q;
            ls_xfer_idx_o <= 5'h00;
        end else if (ls_cnt_q != `FCII_CNT_ZERO && !mem_wait_i) begin
            ls_cnt_q <= ls_cnt_q - `FCII_CNT_ONE;
            if (ls_last) begin
                ls_dst_q      <= {NREG{1'b0}};
                ls_src_q      <= {NREG{1'b0}};
                ls_xfer_idx_o <= 5'h00;
            end else begin
                ls_xfer_idx_o <= ls_xfer_idx_o + 5'h01;
            end
        end
    end

    // registered status toward the host
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stall_o        <= 1'b0;
            issue_go_o     <= 1'b0;
            issue_cancel_o <= 1'b0;
            fwd_used_o     <= 1'b0;
            dp_busy_o      <= 1'b0;
            ls_busy_o      <= 1'b0;
            unavail_o      <= 1'b0;
            ls_restart_o   <= 1'b0;
        end else begin
            // registered from slot_v_d, so it equals slot_v_q and no instruction is accepted into a full slot
            stall_o        <= slot_v_d;
            issue_go_o     <= go;
            issue_cancel_o <= kill;
            fwd_used_o     <= go & |(slot_src_q & dst_lock & fwd_free);
            dp_busy_o      <= (go & is_dp) | ((dp_cnt_q != `FCII_CNT_ZERO) & ~dp_last);
            ls_busy_o      <= (go & is_ls) |
                              ((ls_cnt_q != `FCII_CNT_ZERO) & ~ls_last & ~ls_abort);
            unavail_o      <= (go & is_dp & (slot_len_q != 3'h0)) |
                              (dp_vec_q & ~dp_last);
            ls_restart_o   <= ls_abort;
        end
    end

endmodule // fcii_issue_interlock

//--- design/fcii_lock_bank.v
`timescale 1ns/1ps
`include "fcii_consts.vh"

// one scoreboard: a lock bit per register, set on issue, cleared on release
module fcii_lock_bank #(
    parameter NREG = 32
) (
    input  wire            clock_i,
    input  wire            rst_n_i,
    input  wire [NREG-1:0] set_i,    // locks taken by the issuing instruction
    input  wire [NREG-1:0] clr_i,    // locks released this cycle
    output reg  [NREG-1:0] lock_o    // current lock state
);

    // set wins over clear so a reissue in the release cycle keeps its lock
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_o <= {NREG{1'b0}};
        end else begin
            lock_o <= (lock_o & ~clr_i) | set_i;
        end
    end

endmodule // fcii_lock_bank

//--- test/fcii_host_model.sv
`timescale 1ns/1ps

// host pipeline: offers one instruction and holds it while stalled
module fcii_host_model (
    input  wire        clock_i,
    input  wire        stall_i,  // hold request from the unit
    output reg         valid_o,  // instruction offered
    output reg  [2:0]  class_o,
    output reg  [2:0]  sel_o,
    output reg  [31:0] src_o,
    output reg  [31:0] dst_o,
    output reg  [3:0]  flag_o,   // dbl, integer result, divsqrt, spare
    output reg  [2:0]  len_o,
    output reg  [4:0]  xfer_o,
    output reg         cf_o,     // condition failed on the slot
    output reg         fl_o      // change of flow on the slot
);
    initial {valid_o, class_o, sel_o, src_o, dst_o, flag_o, len_o, xfer_o, cf_o, fl_o} = 0;

    // fields stay put until the accepting edge; then masks inverted, other fields held
    task send(input [2:0] c, input [2:0] s, input [31:0] sm, input [31:0] dm,
              input [3:0] f, input [2:0] l, input [4:0] x, input cf, input fl);
        @(posedge clock_i);
        {valid_o, class_o, sel_o, src_o, dst_o, flag_o, len_o, xfer_o} <= {1'b1, c, s, sm, dm, f, l, x};
        @(posedge clock_i);
        while (stall_i !== 1'b0) @(posedge clock_i);
        valid_o <= 1'b0;
        src_o <= ~sm;
        dst_o <= ~dm;
        cf_o <= cf;
        fl_o <= fl;
        @(posedge clock_i);
        cf_o <= 1'b0;
        fl_o <= 1'b0;
    endtask
endmodule // fcii_host_model

//--- test/fcii_ii_monitor.sv
`timescale 1ns/1ps
`include "fcii_consts.vh"

// watches handshake, cancels, serializers and restart at the ports
module fcii_ii_monitor (
    input wire       clock_i,
    input wire       rst_n_i,
    input wire       instr_valid_i,
    input wire [2:0] instr_class_i,
    input wire       cond_fail_i,
    input wire       flush_i,
    input wire       abort_i,
    input wire       stall_o,
    input wire       issue_go_o,
    input wire       issue_cancel_o,
    input wire       dp_busy_o,
    input wire       ls_busy_o,
    input wire       unavail_o,
    input wire       ls_restart_o,
    input wire [4:0] ls_xfer_idx_o
);
    localparam int MAX_UNAV = 114; // worst vector divide window
    reg [2:0] cls_q;               // class of slot instruction
    reg [7:0] unav_q;              // length of current unavailable run

    // class latched on accept; run counter saturates well past the cap
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cls_q <= 3'h0;
            unav_q <= 8'h00;
        end else begin
            if (instr_valid_i && !stall_o) cls_q <= instr_class_i;
            unav_q <= unavail_o ? (unav_q == 8'hff ? unav_q : unav_q + 8'h01) : 8'h00;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_accept;
        instr_valid_i && !stall_o;
    endsequence
    sequence s_killed;
        issue_cancel_o && !issue_go_o;
    endsequence

    property p_stall_after_accept; s_accept |=> stall_o; endproperty
    a_stall_after_accept: assert property (p_stall_after_accept)
        else $error("stall low after accept");
    property p_stall_release; $fell(stall_o) |-> issue_go_o || issue_cancel_o; endproperty
    a_stall_release: assert property (p_stall_release)
        else $error("stall dropped without go or cancel");
    property p_go_pulse; issue_go_o |=> !issue_go_o; endproperty
    a_go_pulse: assert property (p_go_pulse)
        else $error("issue pulse longer than one cycle");
    property p_cond_cancel; s_accept ##1 cond_fail_i |=> s_killed; endproperty
    a_cond_cancel: assert property (p_cond_cancel)
        else $error("failed condition not cancelled");
    property p_flush_cancel; s_accept ##1 flush_i |=> s_killed; endproperty
    a_flush_cancel: assert property (p_flush_cancel)
        else $error("flush did not cancel slot");
    property p_read_drained;
        issue_go_o && (cls_q == `FCII_CLS_SYS_RD || cls_q == `FCII_CLS_FLAG)
            |-> !$past(dp_busy_o) && !$past(ls_busy_o);
    endproperty
    a_read_drained: assert property (p_read_drained)
        else $error("system read issued with busy pipe");
    property p_unavail_cap; unav_q <= MAX_UNAV; endproperty
    a_unavail_cap: assert property (p_unavail_cap)
        else $error("unavailable run too long");
    property p_abort_restart; abort_i && ls_busy_o |=> ls_restart_o; endproperty
    a_abort_restart: assert property (p_abort_restart)
        else $error("abort gave no restart");
    property p_restart_idx; ls_restart_o |-> ls_xfer_idx_o == 5'h00; endproperty
    a_restart_idx: assert property (p_restart_idx)
        else $error("restart not from first transfer");
endmodule // fcii_ii_monitor

bind fcii_issue_interlock fcii_ii_monitor fcii_ii_monitor_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_class_i(instr_class_i), .cond_fail_i(cond_fail_i), .flush_i(flush_i),
    .abort_i(abort_i), .stall_o(stall_o), .issue_go_o(issue_go_o),
    .issue_cancel_o(issue_cancel_o), .dp_busy_o(dp_busy_o), .ls_busy_o(ls_busy_o),
    .unavail_o(unavail_o), .ls_restart_o(ls_restart_o), .ls_xfer_idx_o(ls_xfer_idx_o));

//--- test/tb.sv
`timescale 1ns/1ps
`include "fcii_consts.vh"

module tb;
    reg         clock_i = 0, rst_n_i = 0, fast_mode_i = 0, abort_i = 0, mem_wait_i = 0;
    wire        instr_valid_i, cond_fail_i, flush_i, stall_o, issue_go_o, issue_cancel_o;
    wire        fwd_used_o, dp_busy_o, ls_busy_o, unavail_o, ls_restart_o;
    wire [2:0]  instr_class_i, sysreg_sel_i, vec_len_i;
    wire [31:0] src_mask_i, dst_mask_i;
    wire [3:0]  flg;
    wire [4:0]  xfer_cnt_i, ls_xfer_idx_o;
    int         err_count = 0, n_checks = 0, cyc = 0, fwd_n = 0;
    int         go_t[$]; // cycles of issue pulses

    fcii_issue_interlock #(.NREG(32)) fcii_issue_interlock_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
        .instr_class_i(instr_class_i), .sysreg_sel_i(sysreg_sel_i), .src_mask_i(src_mask_i),
        .dst_mask_i(dst_mask_i), .dbl_i(flg[0]), .int_result_i(flg[1]), .divsqrt_i(flg[2]),
        .vec_len_i(vec_len_i), .xfer_cnt_i(xfer_cnt_i), .fast_mode_i(fast_mode_i),
        .cond_fail_i(cond_fail_i), .flush_i(flush_i), .abort_i(abort_i),
        .mem_wait_i(mem_wait_i), .stall_o(stall_o), .issue_go_o(issue_go_o),
        .issue_cancel_o(issue_cancel_o), .fwd_used_o(fwd_used_o), .dp_busy_o(dp_busy_o),
        .ls_busy_o(ls_busy_o), .unavail_o(unavail_o), .ls_restart_o(ls_restart_o),
        .ls_xfer_idx_o(ls_xfer_idx_o));
    fcii_host_model fcii_host_model_i (
        .clock_i(clock_i), .stall_i(stall_o), .valid_o(instr_valid_i), .class_o(instr_class_i),
        .sel_o(sysreg_sel_i), .src_o(src_mask_i), .dst_o(dst_mask_i), .flag_o(flg),
        .len_o(vec_len_i), .xfer_o(xfer_cnt_i), .cf_o(cond_fail_i), .fl_o(flush_i));

    initial forever #5 clock_i = ~clock_i;

    // timestamps issues, counts forwards; cuts a hang short
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (issue_go_o === 1'b1) go_t.push_back(cyc);
        if (fwd_used_o === 1'b1) fwd_n <= fwd_n + 1;
        if (cyc >= 20000) begin
            err_count++;
            final_report;
        end
    end

    task final_report;
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // two instructions back to back; gap between their issue pulses
    task pair(input [2:0] c1, input [3:0] f1, input [2:0] c2, input [2:0] s2,
              input [3:0] f2, input [31:0] sm2, input [31:0] dm2, input fm,
              output int gap, output int fw);
        int k;
        fast_mode_i <= fm;
        go_t.delete();
        fwd_n = 0;
        // a long load leaves its dependent time to reach issue
        fcii_host_model_i.send(c1, 0, c1 == `FCII_CLS_LOAD ? 0 : 32'h0000_000c, 32'h0000_0002,
                               f1, 0, c1 == `FCII_CLS_LOAD ? 5'h07 : 5'h00, 0, 0);
        fcii_host_model_i.send(c2, s2, sm2, dm2, f2, 0, 0, 0, 0);
        for (k = 0; k < 400 && go_t.size() < 2; k++) @(posedge clock_i);
        chk("issue count", 2, go_t.size());
        gap = go_t.size() < 2 ? 0 : go_t[1] - go_t[0];
        repeat (40) @(posedge clock_i);
        fw = fwd_n;
    endtask

    // same-precision dp gains one cycle; others do not
    task test_forward;
        logic [2:0] cl[4] = '{`FCII_CLS_DP, `FCII_CLS_STORE, `FCII_CLS_TO_CORE, `FCII_CLS_DP};
        logic [3:0] f1[4] = '{4'h0, 4'h0, 4'h0, 4'h2};
        logic [3:0] f2[4] = '{4'h1, 4'h0, 4'h0, 4'h0};
        int b, fb, g, f, i;
        pair(`FCII_CLS_DP, 0, `FCII_CLS_DP, 0, 0, 32'h2, 32'h100, 0, b, fb);
        chk("forward used", 1, fb != 0);
        for (i = 0; i < 4; i++) begin
            pair(`FCII_CLS_DP, f1[i], cl[i], 0, f2[i], 32'h2, i == 3 ? 32'h100 : 0, 0, g, f);
            chk("unforwarded gap", b + 1, g);
            chk("no forward", 0, f != 0);
        end
    endtask

    // war relaxed in fast mode, waw and load raw blocked
    task test_hazard;
        int gc, gf, gw, gi, f;
        pair(`FCII_CLS_DP, 4'h4, `FCII_CLS_LOAD, 0, 0, 0, 32'h4, 0, gc, f);
        pair(`FCII_CLS_DP, 4'h4, `FCII_CLS_LOAD, 0, 0, 0, 32'h4, 1, gf, f);
        chk("fast war earlier", 1, gf < gc);
        pair(`FCII_CLS_DP, 4'h4, `FCII_CLS_LOAD, 0, 0, 0, 32'h2, 0, gw, f);
        pair(`FCII_CLS_DP, 4'h4, `FCII_CLS_LOAD, 0, 0, 0, 32'h0010_0000, 0, gi, f);
        chk("waw held", 1, gw > gi);
        pair(`FCII_CLS_LOAD, 0, `FCII_CLS_DP, 0, 0, 32'h2, 32'h100, 0, gw, f);
        pair(`FCII_CLS_LOAD, 0, `FCII_CLS_DP, 0, 0, 32'h0020_0000, 32'h100, 0, gi, f);
        chk("load raw held", 1, gw > gi);
    endtask

    // every system access waits behind a divide
    task test_serial;
        int c, s, g, f;
        for (c = `FCII_CLS_SYS_RD; c <= `FCII_CLS_FLAG; c++)
            for (s = `FCII_SEL_ID; s <= `FCII_SEL_SAVED2; s++) begin
                pair(`FCII_CLS_DP, 4'h4, c[2:0], s[2:0], 0, 0, 0, 0, g, f);
                chk("serial wait", 1, g >= `FCII_DS_SP_STEP);
            end
    endtask

    // condition failure, then flush, on the slot
    task test_cancel;
        int i, k, seen;
        for (i = 0; i < 2; i++) begin
            go_t.delete();
            seen = 0;
            fcii_host_model_i.send(`FCII_CLS_DP, 0, 32'h2, 32'h100, 0, 0, 0, i == 0, i == 1);
            for (k = 0; k < 4; k++) begin
                @(posedge clock_i);
                if (issue_cancel_o === 1'b1) seen = 1;
            end
            chk("cancel seen", 1, seen);
            chk("cancel no issue", 0, go_t.size());
        end
    endtask

    // store multiple aborted mid-flight, then reissued to completion
    task test_abort;
        int k, seen;
        mem_wait_i <= 1'b1;
        fcii_host_model_i.send(`FCII_CLS_STORE_MULT, 0, 32'h10, 0, 0, 0, 5'h03, 0, 0);
        for (k = 0; k < 20 && ls_busy_o !== 1'b1; k++) @(posedge clock_i);
        mem_wait_i <= 1'b0;
        @(posedge clock_i);
        // one transfer has moved the index before the abort
        abort_i <= 1'b1;
        @(posedge clock_i);
        abort_i <= 1'b0;
        seen = 0;
        for (k = 0; k < 4; k++) begin
            @(posedge clock_i);
            if (ls_restart_o === 1'b1) seen = 1;
        end
        chk("restart", 1, seen);
        chk("restart index", 0, ls_xfer_idx_o);
        fcii_host_model_i.send(`FCII_CLS_STORE_MULT, 0, 32'h10, 0, 0, 0, 5'h03, 0, 0);
        repeat (20) @(posedge clock_i);
        chk("reissue done", 0, ls_busy_o);
        chk("reissue index", 0, ls_xfer_idx_o);
    endtask

    // eight-iteration single divide: long but bounded window
    task test_vector;
        int k, n;
        n = 0;
        fcii_host_model_i.send(`FCII_CLS_DP, 0, 32'h00ff_0000, 32'h0000_ff00, 4'h4, 3'h7, 0, 0, 0);
        for (k = 0; k < 300; k++) begin
            @(posedge clock_i);
            if (unavail_o === 1'b1) n++;
        end
        chk("unavail cap", 1, n <= `FCII_MAX_UNAVAIL);
        chk("unavail whole", 1, n >= `FCII_DS_SP_STEP * 7);
    endtask

    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        test_forward;
        test_hazard;
        test_serial;
        test_cancel;
        test_abort;
        test_vector;
        final_report;
    end
endmodule // tb
